// ==== logic/interrupt_priority_enable.sv ====
// Per-source interrupt priority and enable registers with a priority arbiter.
// Assumes pending flags arrive as synchronous levels from the peripherals and
// that the core takes the presented request from registered outputs.
//
// Operation
// - Field value 111 is level 7, the highest level.
// - Field value 000 disables the source regardless of enable.
// - Values 001 to 110 map to levels 1 to 6.
// - Reset loads every implemented priority field with 100.
// - Unimplemented priority bits ignore writes and read zero.
// - Checksum error 14-12, serial2 error 10-8, serial1 error 6-4.
// - Serial3 transmit 14-12, receive 10-8, error 6-4.
// - Enable bit 3 change notify, bit 2 comparator.
// - Enable bit 1 I2C master event, bit 0 I2C slave event.
// - Enable one passes the request, zero blocks it.
//
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps

module interrupt_priority_enable
(
   // Clock and reset
   input  wire logic                      core_clk,
   input  wire logic                      rst_n,
   // Register port
   input  wire irq_prio_pkg::reg_req_t    reg_req,
   output logic [15:0]                    reg_rdata,
   // Pending flags: 0-3 compare/capture, 4-6 crc/serial err, 7-9 serial3,
   // 10-11 serial4, 12 change notify, 13 comparator, 14 i2c master
   input  wire logic [14:0]               pend_flags,
   input  wire logic                      i2c_slave_pend,
   // Request to the core
   output irq_prio_pkg::irq_out_t         irq_out,
   output logic [3:0]                     enable_bits
);

   // Stored registers
   logic [15:0]            enable_one_r;
   logic [15:0]            cmp_cap_r;
   logic [15:0]            crc_ser_r;
   logic [15:0]            ser3_r;
   logic [15:0]            ser4_r;
   // Named fields and enables
   logic [2:0]             compare7_priority;
   logic [2:0]             compare6_priority;
   logic [2:0]             compare5_priority;
   logic [2:0]             capture6_priority;
   logic [2:0]             checksum_error_priority;
   logic [2:0]             serial2_error_priority;
   logic [2:0]             serial1_error_priority;
   logic [2:0]             serial3_transmit_priority;
   logic [2:0]             serial3_receive_priority;
   logic [2:0]             serial3_error_priority;
   logic [2:0]             serial4_transmit_priority;
   logic [2:0]             serial4_receive_priority;
   logic                   change_notify_enable;
   logic                   comparator_enable;
   logic                   i2c_master_event_enable;
   logic                   i2c_slave_event_enable;
   // Write selects
   logic                   wr_enable_one;
   logic                   wr_cmp_cap;
   logic                   wr_crc_ser;
   logic                   wr_ser3;
   logic                   wr_ser4;
   // Read path
   logic [15:0]            rdata_nxt;
   logic [15:0]            status_word;
   // Arbiter
   logic [2:0]             lvl       [0:irq_prio_pkg::NUM_SRC];
   logic [15:0]            pend_all;
   logic [15:0]            src_gate;
   logic [15:0]            eff_pend;
   logic [2:0]             grp_lvl   [0:3];
   logic [1:0]             grp_sel   [0:3];
   logic [2:0]             best_lvl_nxt;
   logic [3:0]             best_src_nxt;
   logic                   best_valid_nxt;
   irq_prio_pkg::irq_out_t irq_nxt;

   function automatic logic [15:0] masked(input logic [15:0] d, input logic [15:0] m);
      masked = d & m;
   endfunction

   // status index and unmapped indices select nothing
   always_comb
   begin
      wr_enable_one = 1'b0;
      wr_cmp_cap    = 1'b0;
      wr_crc_ser    = 1'b0;
      wr_ser3       = 1'b0;
      wr_ser4       = 1'b0;
      if (reg_req.wr)
      begin
         case (reg_req.addr)
            irq_prio_pkg::ADDR_ENABLE_ONE:
               wr_enable_one = 1'b1;
            irq_prio_pkg::ADDR_CMP_CAP_PRIO:
               wr_cmp_cap = 1'b1;
            irq_prio_pkg::ADDR_CRC_SER_PRIO:
               wr_crc_ser = 1'b1;
            irq_prio_pkg::ADDR_SER3_PRIO:
               wr_ser3 = 1'b1;
            irq_prio_pkg::ADDR_SER4_PRIO:
               wr_ser4 = 1'b1;
            default:
            begin
            end
         endcase
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         enable_one_r <= irq_prio_pkg::RST_ENABLE_ONE;
      end
      else if (wr_enable_one)
      begin
         enable_one_r <= masked(reg_req.wdata, irq_prio_pkg::MASK_ENABLE_ONE);
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         cmp_cap_r <= irq_prio_pkg::RST_CMP_CAP_PRIO;
      end
      else if (wr_cmp_cap)
      begin
         cmp_cap_r <= masked(reg_req.wdata, irq_prio_pkg::MASK_CMP_CAP_PRIO);
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         crc_ser_r <= irq_prio_pkg::RST_CRC_SER_PRIO;
      end
      else if (wr_crc_ser)
      begin
         crc_ser_r <= masked(reg_req.wdata, irq_prio_pkg::MASK_CRC_SER_PRIO);
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         ser3_r <= irq_prio_pkg::RST_SER3_PRIO;
      end
      else if (wr_ser3)
      begin
         ser3_r <= masked(reg_req.wdata, irq_prio_pkg::MASK_SER3_PRIO);
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         ser4_r <= irq_prio_pkg::RST_SER4_PRIO;
      end
      else if (wr_ser4)
      begin
         ser4_r <= masked(reg_req.wdata, irq_prio_pkg::MASK_SER4_PRIO);
      end
   end

   assign enable_bits = enable_one_r[3:0];

   assign compare7_priority         = cmp_cap_r[irq_prio_pkg::FLD_HI +: 3];
   assign compare6_priority         = cmp_cap_r[irq_prio_pkg::FLD_MH +: 3];
   assign compare5_priority         = cmp_cap_r[irq_prio_pkg::FLD_ML +: 3];
   assign capture6_priority         = cmp_cap_r[irq_prio_pkg::FLD_LO +: 3];
   assign checksum_error_priority   = crc_ser_r[irq_prio_pkg::FLD_HI +: 3];
   assign serial2_error_priority    = crc_ser_r[irq_prio_pkg::FLD_MH +: 3];
   assign serial1_error_priority    = crc_ser_r[irq_prio_pkg::FLD_ML +: 3];
   assign serial3_transmit_priority = ser3_r[irq_prio_pkg::FLD_HI +: 3];
   assign serial3_receive_priority  = ser3_r[irq_prio_pkg::FLD_MH +: 3];
   assign serial3_error_priority    = ser3_r[irq_prio_pkg::FLD_ML +: 3];
   assign serial4_transmit_priority = ser4_r[irq_prio_pkg::FLD_ML +: 3];
   assign serial4_receive_priority  = ser4_r[irq_prio_pkg::FLD_LO +: 3];

   assign change_notify_enable    = enable_one_r[irq_prio_pkg::EN_CHANGE_NOTIFY];
   assign comparator_enable       = enable_one_r[irq_prio_pkg::EN_COMPARATOR];
   assign i2c_master_event_enable = enable_one_r[irq_prio_pkg::EN_I2C_MASTER];
   assign i2c_slave_event_enable  = enable_one_r[irq_prio_pkg::EN_I2C_SLAVE];

   // Field map, one slot per source; slot 15 is the I2C slave event
   assign lvl[0]  = compare7_priority;
   assign lvl[1]  = compare6_priority;
   assign lvl[2]  = compare5_priority;
   assign lvl[3]  = capture6_priority;
   assign lvl[4]  = checksum_error_priority;
   assign lvl[5]  = serial2_error_priority;
   assign lvl[6]  = serial1_error_priority;
   assign lvl[7]  = serial3_transmit_priority;
   assign lvl[8]  = serial3_receive_priority;
   assign lvl[9]  = serial3_error_priority;
   assign lvl[10] = serial4_transmit_priority;
   assign lvl[11] = serial4_receive_priority;
   // Enable-gated sources have no priority field here; fixed level 4
   assign lvl[12] = 3'h4;
   assign lvl[13] = 3'h4;
   assign lvl[14] = 3'h4;
   assign lvl[15] = 3'h4;

   assign pend_all = {i2c_slave_pend, pend_flags};

   // sources 12 to 15 pass only with their enable bit
   assign src_gate = {i2c_slave_event_enable,
                      i2c_master_event_enable,
                      comparator_enable,
                      change_notify_enable,
                      12'hfff};

   // a zero field drops its source before arbitration
   for (genvar s = 0; s <= irq_prio_pkg::NUM_SRC; s++)
   begin : g_src
      assign eff_pend[s] = pend_all[s] & src_gate[s]
                           & (lvl[s] != irq_prio_pkg::LEVEL_OFF);
   end

   // first stage over four neighbours; two stages keep the chain short
   for (genvar g = 0; g < 4; g++)
   begin : g_grp
      logic [2:0] lvl_g;
      logic [1:0] sel_g;

      always_comb
      begin
         lvl_g = irq_prio_pkg::LEVEL_OFF;
         sel_g = 2'h0;
         for (int k = 0; k < 4; k++)
         begin
            if (eff_pend[4 * g + k] && lvl[4 * g + k] > lvl_g)
            begin
               lvl_g = lvl[4 * g + k];
               sel_g = 2'(k);
            end
         end
      end

      assign grp_lvl[g] = lvl_g;
      assign grp_sel[g] = sel_g;
   end

   // second stage; strict compare keeps the lower index on a tie
   always_comb
   begin
      best_lvl_nxt = irq_prio_pkg::LEVEL_OFF;
      best_src_nxt = 4'h0;
      for (int j = 0; j < 4; j++)
      begin
         if (grp_lvl[j] > best_lvl_nxt)
         begin
            best_lvl_nxt = grp_lvl[j];
            best_src_nxt = {2'(j), grp_sel[j]};
         end
      end
   end

   assign best_valid_nxt = (best_lvl_nxt != irq_prio_pkg::LEVEL_OFF);

   // Packed request toward the core
   always_comb
   begin
      irq_nxt        = '0;
      irq_nxt.valid  = best_valid_nxt;
      irq_nxt.source = best_src_nxt;
      irq_nxt.level  = best_lvl_nxt;
   end

   // Registered so the core never sees arbiter glitches
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         irq_out <= '0;
      end
      else
      begin
         irq_out <= irq_nxt;
      end
   end

   // Live arbiter view, read-only
   assign status_word = {8'h00, best_src_nxt, best_valid_nxt, best_lvl_nxt};

   // readback, masked so unimplemented bits read zero
   always_comb
   begin
      case (reg_req.addr)
         irq_prio_pkg::ADDR_ENABLE_ONE:
            rdata_nxt = enable_one_r & irq_prio_pkg::MASK_ENABLE_ONE;
         irq_prio_pkg::ADDR_CMP_CAP_PRIO:
            rdata_nxt = cmp_cap_r & irq_prio_pkg::MASK_CMP_CAP_PRIO;
         irq_prio_pkg::ADDR_CRC_SER_PRIO:
            rdata_nxt = crc_ser_r & irq_prio_pkg::MASK_CRC_SER_PRIO;
         irq_prio_pkg::ADDR_SER3_PRIO:
            rdata_nxt = ser3_r & irq_prio_pkg::MASK_SER3_PRIO;
         irq_prio_pkg::ADDR_SER4_PRIO:
            rdata_nxt = ser4_r & irq_prio_pkg::MASK_SER4_PRIO;
         irq_prio_pkg::ADDR_STATUS:
            rdata_nxt = status_word;
         default:
            rdata_nxt = 16'h0000;
      endcase
   end

   // Read data only in the cycle after the strobe
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         reg_rdata <= 16'h0000;
      end
      else if (reg_req.rd)
      begin
         reg_rdata <= rdata_nxt;
      end
      else
      begin
         reg_rdata <= 16'h0000;
      end
   end

endmodule

// ==== logic/irq_prio_pkg.sv ====
// Package for the per-source interrupt priority and enable block.
// Assumes a 16-bit register port with one-cycle read latency.
package irq_prio_pkg;

   // Register indices on the plain register port
   localparam logic [2:0] ADDR_ENABLE_ONE   = 3'h0;
   localparam logic [2:0] ADDR_CMP_CAP_PRIO = 3'h1;
   localparam logic [2:0] ADDR_CRC_SER_PRIO = 3'h2;
   localparam logic [2:0] ADDR_SER3_PRIO    = 3'h3;
   localparam logic [2:0] ADDR_SER4_PRIO    = 3'h4;
   localparam logic [2:0] ADDR_STATUS       = 3'h5;

   // Implemented-bit masks per register
   localparam logic [15:0] MASK_ENABLE_ONE   = 16'h000f;
   localparam logic [15:0] MASK_CMP_CAP_PRIO = 16'h7777;
   localparam logic [15:0] MASK_CRC_SER_PRIO = 16'h7770;
   localparam logic [15:0] MASK_SER3_PRIO    = 16'h7770;
   localparam logic [15:0] MASK_SER4_PRIO    = 16'h0077;

   // Reset values: every field level 4
   localparam logic [15:0] RST_ENABLE_ONE   = 16'h0000;
   localparam logic [15:0] RST_CMP_CAP_PRIO = 16'h4444;
   localparam logic [15:0] RST_CRC_SER_PRIO = 16'h4440;
   localparam logic [15:0] RST_SER3_PRIO    = 16'h4440;
   localparam logic [15:0] RST_SER4_PRIO    = 16'h0044;

   // Enable bit positions
   localparam int EN_CHANGE_NOTIFY = 3;
   localparam int EN_COMPARATOR    = 2;
   localparam int EN_I2C_MASTER    = 1;
   localparam int EN_I2C_SLAVE     = 0;

   // Field positions (low bit of each three-bit field)
   localparam int FLD_HI  = 12;
   localparam int FLD_MH  = 8;
   localparam int FLD_ML  = 4;
   localparam int FLD_LO  = 0;

   localparam int          NUM_SRC     = 15;
   localparam logic [2:0]  LEVEL_OFF   = 3'h0;

   typedef struct packed
   {
      logic [2:0] addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } reg_req_t;

   typedef struct packed
   {
      logic       valid;
      logic [3:0] source;
      logic [2:0] level;
   } irq_out_t;

endpackage

// ==== verif/irq_prio_asserts.sv ====
// Checker for the priority and enable block, bound to its ports.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module irq_prio_asserts
(
   // Watched ports
   input wire logic                   core_clk,
   input wire logic                   rst_n,
   input wire irq_prio_pkg::reg_req_t reg_req,
   input wire logic [15:0]            reg_rdata,
   input wire logic [14:0]            pend_flags,
   input wire logic                   i2c_slave_pend,
   input wire irq_prio_pkg::irq_out_t irq_out,
   input wire logic [3:0]             enable_bits
);
   logic [15:0] pend_q;
   wire         en_wr = reg_req.wr && reg_req.addr == 3'h0;
   always_ff @(posedge core_clk)
      pend_q <= {i2c_slave_pend, pend_flags};
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   a_rdata_idle: assert property (!reg_req.rd |=> reg_rdata == 16'h0)
      else $error("read data not idle");
   a_gap_bits: assert property (reg_req.rd && reg_req.addr inside {[3'h1:3'h4]}
      |=> (reg_rdata & 16'h8888) == 16'h0) else $error("gap bit read nonzero");
   a_enable_read: assert property (reg_req.rd && reg_req.addr == 3'h0
      |=> reg_rdata == {12'h0, enable_bits}) else $error("enable readback");
   a_enable_write: assert property (en_wr
      |=> {12'h0, enable_bits} == ($past(reg_req.wdata) & 16'h000f)) else $error("enable write");
   a_enable_hold: assert property (!en_wr |=> $stable(enable_bits))
      else $error("enable changed");
   a_zero_level: assert property (irq_out.valid |-> irq_out.level != 3'h0)
      else $error("level zero presented");
   a_slave_gate: assert property (irq_out.valid && irq_out.source == 4'hf
      |-> ($past(enable_bits) & 4'h1) != 4'h0) else $error("slave not enabled");
   a_idle_quiet: assert property (pend_flags == 15'h0 && !i2c_slave_pend
      |=> !irq_out.valid) else $error("request with none pending");
   a_src_pending: assert property (irq_out.valid |-> pend_q[irq_out.source])
      else $error("winner not pending");
   cover property (irq_out.valid && irq_out.level == 3'h7);
   cover property (irq_out.valid && irq_out.source == 4'hf);
   cover property (en_wr);
endmodule

bind interrupt_priority_enable irq_prio_asserts chk_u (.core_clk(core_clk), .rst_n(rst_n),
   .reg_req(reg_req), .reg_rdata(reg_rdata), .pend_flags(pend_flags),
   .i2c_slave_pend(i2c_slave_pend), .irq_out(irq_out), .enable_bits(enable_bits));

// ==== verif/interrupt_priority_enable_tb.sv ====
// Self-checking bench for the priority and enable block.
// Assumes the checker file is compiled beside it.
`timescale 1ns/1ps
module interrupt_priority_enable_tb;
   logic                   core_clk = 1'b0;
   logic                   rst_n = 1'b0;
   irq_prio_pkg::reg_req_t req = '0;
   logic [15:0]            reg_rdata;
   logic [15:0]            pend = 16'h0;
   irq_prio_pkg::irq_out_t irq_out;
   logic [3:0]             enable_bits;
   logic                   rd_d = 1'b0;
   logic [2:0]             rd_a = 3'h0;
   logic [7:0]             ei;
   logic [15:0]            exp_q[$];
   logic [15:0]            e;
   int                     n_mismatch = 0;
   int                     num_checks = 0;
   logic [15:0]            mk [5] = '{irq_prio_pkg::MASK_ENABLE_ONE,
      irq_prio_pkg::MASK_CMP_CAP_PRIO, irq_prio_pkg::MASK_CRC_SER_PRIO,
      irq_prio_pkg::MASK_SER3_PRIO, irq_prio_pkg::MASK_SER4_PRIO};
   always #10 core_clk = ~core_clk;
   interrupt_priority_enable dut_u
   (
      .core_clk       (core_clk),
      .rst_n          (rst_n),
      .reg_req        (req),
      .reg_rdata      (reg_rdata),
      .pend_flags     (pend[14:0]),
      .i2c_slave_pend (pend[15]),
      .irq_out        (irq_out),
      .enable_bits    (enable_bits)
   );
   task automatic results();
      if (n_mismatch == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // A read carries its expected data in d; wdata is ignored on reads
   task automatic op(input logic w, input logic r, input logic [2:0] a, input logic [15:0] d);
      @(posedge core_clk);
      req <= '{addr: a, wdata: d, wr: w, rd: r};
      if (r)
         exp_q.push_back(d);
   endtask
   task automatic pnd(input logic [15:0] v);
      @(posedge core_clk);
      pend <= v;
      req <= '0;
   endtask
   function automatic logic [15:0] st(input logic [3:0] s, input logic [2:0] l);
      return {8'h0, s, 1'b1, l};
   endfunction
   always @(posedge core_clk)
   begin
      rd_d <= req.rd;
      rd_a <= req.addr;
   end
   always @(negedge core_clk)
      if (rd_d)
      begin
         e = exp_q.pop_front();
         num_checks++;
         if (reg_rdata !== e)
         begin
            n_mismatch++;
            $display("Error reg_rdata expected %h seen %h", e, reg_rdata);
         end
         if (rd_a == irq_prio_pkg::ADDR_STATUS)
         begin
            ei = {e[3], e[7:4], e[2:0]};
            num_checks++;
            if (irq_out !== ei)
            begin
               n_mismatch++;
               $display("Error irq_out expected %h seen %h", ei, irq_out);
            end
         end
         if (rd_a == irq_prio_pkg::ADDR_ENABLE_ONE)
         begin
            num_checks++;
            if (enable_bits !== e[3:0])
            begin
               n_mismatch++;
               $display("Error enable_bits expected %h seen %h", e[3:0], enable_bits);
            end
         end
      end
   initial
   begin
      repeat (2000) @(posedge core_clk);
      n_mismatch++;
      results();
   end
   initial
   begin
      logic [15:0] r;
      void'($urandom(94703));
      repeat (10) @(posedge core_clk);
      rst_n <= 1'b1;
      op(0, 1, 3'h0, irq_prio_pkg::RST_ENABLE_ONE);
      op(0, 1, 3'h1, irq_prio_pkg::RST_CMP_CAP_PRIO);
      op(0, 1, 3'h2, irq_prio_pkg::RST_CRC_SER_PRIO);
      op(0, 1, 3'h3, irq_prio_pkg::RST_SER3_PRIO);
      op(0, 1, 3'h4, irq_prio_pkg::RST_SER4_PRIO);
      op(1, 0, 3'h5, 16'hffff);
      op(1, 0, 3'h7, 16'hffff);
      op(0, 1, 3'h0, 16'h0);
      op(0, 1, 3'h5, 16'h0);
      op(0, 1, 3'h7, 16'h0);
      for (int i = 0; i < 5; i++)
      begin
         r = 16'($urandom);
         op(1, 0, i[2:0], r);
         op(0, 1, i[2:0], r & mk[i]);
         op(1, 0, i[2:0], 16'h0);
      end
      op(1, 0, 3'h2, 16'h1000);
      for (int l = 0; l < 8; l++)
      begin
         op(1, 0, 3'h1, {1'b0, l[2:0], 12'h0});
         pnd(16'h0011);
         op(0, 1, 3'h5, (l != 0) ? st(4'h0, l[2:0]) : st(4'h4, 3'h1));
      end
      op(1, 0, 3'h3, 16'h0700);
      pnd(16'h0180);
      op(0, 1, 3'h5, st(4'h8, 3'h7));
      op(1, 0, 3'h2, 16'h0060);
      pnd(16'h0060);
      op(0, 1, 3'h5, st(4'h6, 3'h6));
      for (int b = 0; b < 4; b++)
      begin
         pnd(16'h8000 >> b);
         op(1, 0, 3'h0, 16'h1 << b);
         op(0, 1, 3'h5, st(4'hf - b[3:0], 3'h4));
         op(1, 0, 3'h0, ~(16'h1 << b));
         op(0, 1, 3'h5, 16'h0);
      end
      op(0, 0, 3'h0, 16'h0);
      repeat (3) @(posedge core_clk);
      results();
   end
endmodule
